// [rtl/reset_cause_and_delay_sequencer.sv]
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module reset_cause_and_delay_sequencer #(
    parameter int unsigned POWER_UP_TIMER_CYC  = reset_seq_pkg::POWER_UP_TIMER_DELAY_CYC,
    parameter int unsigned LOCK_CYC  = reset_seq_pkg::PLL_LOCK_CYC,
    parameter int unsigned FAIL_SAFE_MONITOR_CYC  = reset_seq_pkg::FAIL_SAFE_MONITOR_DELAY_CYC,
    parameter int unsigned TRST_CYC  = reset_seq_pkg::INT_RESET_CYC
) (
    input  wire logic                              clk_i,
    input  wire logic                              rst_b_i,
    input  wire logic [reset_seq_pkg::ADDR_W-1:0]  avs_address_i,
    input  wire logic                              avs_read_i,
    input  wire logic                              avs_write_i,
    input  wire logic [31:0]                       avs_writedata_i,
    output logic      [31:0]                       avs_readdata_o,
    output logic                                   avs_waitrequest_o,
    input  wire logic                              brownout_i,
    input  wire logic                              master_clear_pin_b_i,
    input  wire logic                              osc_clk_i,
    input  wire logic                              watchdog_expire_i,
    input  wire logic                              reset_instr_i,
    input  wire logic                              illegal_op_i,
    input  wire logic                              trap_conflict_i,
    input  wire logic                              config_mismatch_i,
    input  wire logic                              power_save_instruction_i,
    input  wire logic                              power_save_idle_i,
    input  wire logic [15:0]                       config_word_two_i,
    input  wire logic                              clock_switch_en_i,
    input  wire logic                              regulator_enable_i,
    input  wire logic                              watchdog_fuse_enable_i,
    output logic                                   system_reset_o,
    output logic                                   clock_release_o,
    output logic                                   cpu_run_o,
    output logic                                   fail_safe_monitor_o,
    output logic      [2:0]                        osc_select_o,
    output logic                                   watchdog_enable_o
);
    import reset_seq_pkg::*;

    // ---------------- pin synchronisers ----------------
    logic [2:0] bor_s_r, master_clear_pin_s_r, osc_s_r;
    logic       bor_q_r, master_clear_pin_q_r, osc_q_r;
    logic       bor_now, master_clear_pin_now, osc_now;
    logic       bor_evt, pin_evt, osc_rise;

    // a level only counts once the second and third stages agree
    always_comb begin
        bor_now  = (bor_s_r[1] == bor_s_r[2]) ? bor_s_r[2] : bor_q_r;
        master_clear_pin_now = (master_clear_pin_s_r[1] == master_clear_pin_s_r[2]) ? master_clear_pin_s_r[2] : master_clear_pin_q_r;
        osc_now  = (osc_s_r[1] == osc_s_r[2]) ? osc_s_r[2] : osc_q_r;
        bor_evt  = bor_now & ~bor_q_r;
        pin_evt  = master_clear_pin_q_r & ~master_clear_pin_now;
        osc_rise = osc_now & ~osc_q_r;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bor_s_r  <= 3'h0;
            master_clear_pin_s_r <= 3'h7;
            osc_s_r  <= 3'h0;
            bor_q_r  <= 1'b0;
            master_clear_pin_q_r <= 1'b1;
            osc_q_r  <= 1'b0;
        end else begin
            bor_s_r  <= {bor_s_r[1:0], brownout_i};
            master_clear_pin_s_r <= {master_clear_pin_s_r[1:0], master_clear_pin_b_i};
            osc_s_r  <= {osc_s_r[1:0], osc_clk_i};
            bor_q_r  <= bor_now;
            master_clear_pin_q_r <= master_clear_pin_now;
            osc_q_r  <= osc_now;
        end
    end

    // ---------------- reset events ----------------
    logic [15:0] status_r, status_nxt;
    logic [15:0] osc_ctl_r, osc_ctl_nxt;
    logic       restart_r;
    logic       start;
    logic       hard_kind;
    logic       other_evt;
    logic [2:0] init_osc;
    logic [2:0] sel_osc;
    logic       pri_crystal;
    logic       sel_xtal, sel_pll;

    // restart_r stands for the power-on reset, caught after release
    always_comb begin
        other_evt   = pin_evt | watchdog_expire_i | reset_instr_i | illegal_op_i
                    | trap_conflict_i | config_mismatch_i;
        start       = restart_r | bor_evt | other_evt;
        hard_kind   = restart_r | bor_evt;
        init_osc    = config_word_two_i[OSC_INIT_LSB +: 3];
        pri_crystal = (config_word_two_i[PRI_MODE_LSB +: 2] != PRI_EXT_CLK);
        sel_osc     = (clock_switch_en_i && !hard_kind) ? osc_ctl_r[OSC_CUR_LSB +: 3]
                                                         : init_osc;
        sel_xtal    = ((sel_osc == OSC_PRI || sel_osc == OSC_PRI_PLL) && pri_crystal)
                    || (sel_osc == OSC_SEC);
        sel_pll     = (sel_osc == OSC_PRI_PLL) || (sel_osc == OSC_FRC_PLL);
    end

    // ---------------- register bus ----------------
    logic        wait_r, wait_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        bus_take;
    logic        wr_status, wr_osc;

    // one wait state: answer prepared on the first cycle, taken on the second
    always_comb begin
        bus_take  = (avs_read_i | avs_write_i) & ~wait_r;
        wr_status = bus_take & avs_write_i & (avs_address_i == STATUS_OFS);
        wr_osc    = bus_take & avs_write_i & (avs_address_i == OSC_CTL_OFS);
        wait_nxt  = ~((avs_read_i | avs_write_i) & wait_r);
        rdata_nxt = rdata_r;
        if ((avs_read_i | avs_write_i) && wait_r) begin
            case (avs_address_i)
                STATUS_OFS:  rdata_nxt = {16'h0000, status_r};
                OSC_CTL_OFS: rdata_nxt = {16'h0000, osc_ctl_r};
                default:     rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // flags: software writes first, hardware sets last so a set wins
    always_comb begin
        status_nxt  = status_r;
        osc_ctl_nxt = osc_ctl_r;
        if (wr_status) begin
            status_nxt = avs_writedata_i[15:0] & STATUS_MASK;
        end
        if (wr_osc) begin
            osc_ctl_nxt = avs_writedata_i[15:0] & OSC_CTL_MASK;
        end
        if (start) begin
            osc_ctl_nxt[OSC_CUR_LSB +: 3] = sel_osc;
        end
        if (power_save_instruction_i) begin
            status_nxt[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
            if (power_save_idle_i) begin
                status_nxt[IDLE_BIT] = 1'b1;
            end else begin
                status_nxt[SLEEP_BIT] = 1'b1;
            end
        end
        if (bor_evt)           status_nxt[BOR_BIT]     = 1'b1;
        if (pin_evt)           status_nxt[PIN_BIT]     = 1'b1;
        if (watchdog_expire_i) status_nxt[WATCHDOG_TIMEOUT_FLAG_BIT]    = 1'b1;
        if (reset_instr_i)     status_nxt[SWR_BIT]     = 1'b1;
        if (illegal_op_i)      status_nxt[ILLEGAL_BIT] = 1'b1;
        if (trap_conflict_i)   status_nxt[TRAP_BIT]    = 1'b1;
        if (config_mismatch_i) status_nxt[CM_BIT]      = 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            status_r  <= STATUS_RST;
            osc_ctl_r <= OSC_CTL_RST;
            wait_r    <= 1'b1;
            rdata_r   <= 32'h0000_0000;
        end else begin
            status_r  <= status_nxt;
            osc_ctl_r <= osc_ctl_nxt;
            wait_r    <= wait_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ---------------- delay timers ----------------
    delay_timer_if sys_t ();
    delay_timer_if lock_t ();
    delay_timer_if fail_safe_monitor_t ();

    delay_timer u_sys_timer (.clk_i(clk_i), .rst_b_i(rst_b_i), .tif(sys_t.timer));
    delay_timer u_lock_timer (.clk_i(clk_i), .rst_b_i(rst_b_i), .tif(lock_t.timer));
    delay_timer u_fail_safe_monitor_timer (.clk_i(clk_i), .rst_b_i(rst_b_i), .tif(fail_safe_monitor_t.timer));

    // ---------------- system reset sequence ----------------
    sys_state_t          sys_r, sys_nxt;
    logic [TIMER_W-1:0]  startup_len;
    logic                sys_release;

    always_comb begin
        startup_len = regulator_enable_i ? TIMER_W'(REG_DELAY_CYC) : TIMER_W'(POWER_UP_TIMER_CYC);
        sys_nxt     = sys_r;
        sys_t.load  = 1'b0;
        sys_t.len   = '0;
        if (start) begin
            sys_t.load = 1'b1;
            if (restart_r) begin
                sys_nxt   = SYS_POR;
                sys_t.len = TIMER_W'(POR_DELAY_CYC);
            end else if (bor_evt) begin
                sys_nxt   = SYS_START;
                sys_t.len = startup_len;
            end else begin
                sys_nxt   = SYS_INTRST;
                sys_t.len = TIMER_W'(TRST_CYC);
            end
        end else begin
            case (sys_r)
                SYS_POR: begin
                    if (sys_t.done) begin
                        sys_nxt    = SYS_START;
                        sys_t.load = 1'b1;
                        sys_t.len  = startup_len;
                    end
                end
                SYS_START: begin
                    if (sys_t.done) begin
                        sys_nxt    = SYS_INTRST;
                        sys_t.load = 1'b1;
                        sys_t.len  = TIMER_W'(TRST_CYC);
                    end
                end
                SYS_INTRST: begin
                    // a pin still held low keeps the internal reset running
                    if (!master_clear_pin_q_r) begin
                        sys_t.load = 1'b1;
                        sys_t.len  = TIMER_W'(TRST_CYC);
                    end else if (sys_t.done) begin
                        sys_nxt = SYS_RUN;
                    end
                end
                SYS_RUN: sys_nxt = SYS_RUN;
                default: sys_nxt = SYS_POR;
            endcase
        end
        sys_release = (sys_r == SYS_INTRST) && (sys_nxt == SYS_RUN);
    end

    // ---------------- clock release sequence ----------------
    clk_state_t      clk_r, clk_nxt;
    logic [OST_W-1:0] ost_r, ost_nxt;
    logic            pll_r, pll_nxt;
    logic            fail_safe_monitor_need_r, fail_safe_monitor_need_nxt;

    // runs beside the reset delay, not after it
    always_comb begin
        clk_nxt       = clk_r;
        ost_nxt       = ost_r;
        pll_nxt       = pll_r;
        fail_safe_monitor_need_nxt = fail_safe_monitor_need_r;
        lock_t.load   = 1'b0;
        lock_t.len    = '0;
        if (start) begin
            pll_nxt       = sel_pll;
            ost_nxt       = '0;
            fail_safe_monitor_need_nxt = hard_kind && (sel_xtal || sel_pll);
            lock_t.load   = 1'b1;
            if (!hard_kind) begin
                clk_nxt = CK_READY;
            end else if (sel_xtal) begin
                clk_nxt = CK_OST;
            end else if (sel_pll) begin
                clk_nxt    = CK_LOCK;
                lock_t.len = TIMER_W'(LOCK_CYC);
            end else begin
                clk_nxt = CK_READY;
            end
        end else begin
            case (clk_r)
                CK_OST: begin
                    if (osc_rise) begin
                        ost_nxt = ost_r + 1'b1;
                        if (ost_r == OST_LAST) begin
                            if (pll_r) begin
                                clk_nxt     = CK_LOCK;
                                lock_t.load = 1'b1;
                                lock_t.len  = TIMER_W'(LOCK_CYC);
                            end else begin
                                clk_nxt = CK_READY;
                            end
                        end
                    end
                end
                CK_LOCK:  if (lock_t.done) clk_nxt = CK_READY;
                CK_READY: clk_nxt = CK_READY;
                default:  clk_nxt = CK_READY;
            endcase
        end
    end

    // ---------------- fail-safe monitor start ----------------
    logic mon_r, mon_nxt;

    always_comb begin
        mon_nxt     = mon_r;
        fail_safe_monitor_t.load = 1'b0;
        fail_safe_monitor_t.len  = '0;
        if (start) begin
            mon_nxt     = 1'b0;
            fail_safe_monitor_t.load = 1'b1;
        end else if (sys_release) begin
            if (fail_safe_monitor_need_r) begin
                fail_safe_monitor_t.load = 1'b1;
                fail_safe_monitor_t.len  = TIMER_W'(FAIL_SAFE_MONITOR_CYC);
            end else begin
                mon_nxt = 1'b1;
            end
        end else if (fail_safe_monitor_t.done && sys_r == SYS_RUN) begin
            mon_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            restart_r         <= 1'b1;
            sys_r             <= SYS_POR;
            clk_r             <= CK_READY;
            ost_r             <= '0;
            pll_r             <= 1'b0;
            fail_safe_monitor_need_r       <= 1'b0;
            mon_r             <= 1'b0;
            system_reset_o    <= 1'b1;
            clock_release_o   <= 1'b0;
            cpu_run_o         <= 1'b0;
            osc_select_o      <= OSC_FRC;
            watchdog_enable_o <= 1'b1;
        end else begin
            restart_r         <= 1'b0;
            sys_r             <= sys_nxt;
            clk_r             <= clk_nxt;
            ost_r             <= ost_nxt;
            pll_r             <= pll_nxt;
            fail_safe_monitor_need_r       <= fail_safe_monitor_need_nxt;
            mon_r             <= mon_nxt;
            system_reset_o    <= (sys_nxt != SYS_RUN);
            clock_release_o   <= (clk_nxt == CK_READY);
            cpu_run_o         <= (sys_nxt == SYS_RUN) && (clk_nxt == CK_READY);
            osc_select_o      <= start ? sel_osc : osc_select_o;
            watchdog_enable_o <= watchdog_fuse_enable_i | status_nxt[SOFT_WDT_BIT];
        end
    end

    assign avs_readdata_o      = rdata_r;
    assign avs_waitrequest_o   = wait_r;
    assign fail_safe_monitor_o = mon_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_por_flags: assert property (restart_r |-> status_r == STATUS_RST)
        else $error("power-on flags wrong");
    a_trap_flag: assert property (trap_conflict_i |=> status_r[TRAP_BIT])
        else $error("trap flag not set");
    a_illegal_flag: assert property (illegal_op_i |=> status_r[ILLEGAL_BIT])
        else $error("illegal-op flag not set");
    a_mismatch_flag: assert property (config_mismatch_i |=> status_r[CM_BIT])
        else $error("mismatch flag not set");
    a_pin_flag: assert property (pin_evt |=> status_r[PIN_BIT] && system_reset_o)
        else $error("pin reset not recorded");
    a_watchdog_timeout_flag_clear: assert property (power_save_instruction_i && !watchdog_expire_i && !wr_status
        |=> !status_r[WATCHDOG_TIMEOUT_FLAG_BIT])
        else $error("watchdog flag not cleared");
    a_idle_flag: assert property (power_save_instruction_i && power_save_idle_i && !wr_status
        |=> status_r[IDLE_BIT] [*2])
        else $error("idle flag lost");
    a_write_no_reset: assert property (sys_r == SYS_RUN && bus_take && !start
        |=> !system_reset_o)
        else $error("register write caused reset");
    a_release_path: assert property ($fell(system_reset_o) |-> $past(sys_r) == SYS_INTRST)
        else $error("reset released early");
    a_other_delay: assert property (start && !hard_kind && master_clear_pin_now |=> system_reset_o [*8])
        else $error("internal reset too short");
    a_select_fixed: assert property (start && !clock_switch_en_i |=> osc_select_o == $past(init_osc))
        else $error("clock source not from configuration");
    a_run_needs_clock: assert property (cpu_run_o |-> clock_release_o && !system_reset_o)
        else $error("code runs without clock");
    a_monitor_after: assert property (fail_safe_monitor_o |-> !system_reset_o)
        else $error("monitor active in reset");
    a_fuse_watchdog: assert property (watchdog_fuse_enable_i |=> watchdog_enable_o)
        else $error("watchdog not forced on");

    c_pin_reset: cover property (pin_evt ##[1:100] !system_reset_o);
    c_monitor_on: cover property ($rose(fail_safe_monitor_o));
    c_code_runs: cover property ($rose(cpu_run_o));
endmodule
`default_nettype wire

// [inc/reset_seq_pkg.sv]
// Summary of operation
// - illegal-op and trap flags set; power-on clears
// - config mismatch reset sets bit 9
// - pin reset sets bit 7
// - watchdog expiry sets bit 4; power-save clears
// - idle entry sets bit 2 until cleared
// - flag writes only store, never reset
// - switching on: power/brownout use initial, else current
// - switching off: always initial oscillator field
// - system reset held until delays expire
// - oscillator waits run alongside reset delay
// - clock monitor starts after release plus delay
// - delay chain depends on reset kind
// - power-on delay is 10 us
// - start-up: regulator 10 us, else 64 ms
// - crystal waits 1024 oscillator periods, then lock if PLL
// - PLL lock wait 2 ms after power/brownout
// - monitor delay only crystal/PLL after power/brownout
// - fuse bit one forces watchdog enabled
// - power-on sets brownout and power flags only
package reset_seq_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned POR_DELAY_NS  = 10000;
    localparam int unsigned REG_DELAY_NS  = 10000;
    localparam int unsigned POWER_UP_TIMER_DELAY_MS = 64;
    localparam int unsigned PLL_LOCK_MS   = 2;
    localparam int unsigned FAIL_SAFE_MONITOR_DELAY_US = 100;
    localparam int unsigned POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned REG_DELAY_CYC = (REG_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POWER_UP_TIMER_DELAY_CYC = POWER_UP_TIMER_DELAY_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned PLL_LOCK_CYC   = PLL_LOCK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned FAIL_SAFE_MONITOR_DELAY_CYC = FAIL_SAFE_MONITOR_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int unsigned INT_RESET_CYC  = 8;
    localparam int unsigned TIMER_W        = 24;
    localparam int unsigned OST_W          = 10;
    localparam logic [OST_W-1:0] OST_LAST  = 10'h3FF;

    localparam int unsigned ADDR_W      = 4;
    localparam logic [3:0]  STATUS_OFS  = 4'h0;
    localparam logic [3:0]  OSC_CTL_OFS = 4'h4;

    localparam int unsigned TRAP_BIT     = 15;
    localparam int unsigned ILLEGAL_BIT  = 14;
    localparam int unsigned CM_BIT       = 9;
    localparam int unsigned PIN_BIT      = 7;
    localparam int unsigned SWR_BIT      = 6;
    localparam int unsigned SOFT_WDT_BIT = 5;
    localparam int unsigned WATCHDOG_TIMEOUT_FLAG_BIT     = 4;
    localparam int unsigned SLEEP_BIT    = 3;
    localparam int unsigned IDLE_BIT     = 2;
    localparam int unsigned BOR_BIT      = 1;
    localparam logic [15:0] STATUS_MASK  = 16'hC3FF;
    localparam logic [15:0] STATUS_RST   = 16'h0003;
    localparam logic [15:0] OSC_CTL_MASK = 16'h7000;
    localparam logic [15:0] OSC_CTL_RST  = 16'h0000;

    localparam int unsigned OSC_CUR_LSB  = 12;
    localparam int unsigned OSC_INIT_LSB = 8;
    localparam int unsigned PRI_MODE_LSB = 0;
    localparam logic [2:0]  OSC_FRC      = 3'h0;
    localparam logic [2:0]  OSC_FRC_PLL  = 3'h1;
    localparam logic [2:0]  OSC_PRI      = 3'h2;
    localparam logic [2:0]  OSC_PRI_PLL  = 3'h3;
    localparam logic [2:0]  OSC_SEC      = 3'h4;
    localparam logic [1:0]  PRI_EXT_CLK  = 2'h0;

    typedef enum logic [3:0] {
        SYS_POR    = 4'h1,
        SYS_START  = 4'h2,
        SYS_INTRST = 4'h4,
        SYS_RUN    = 4'h8
    } sys_state_t;
    typedef enum logic [2:0] {
        CK_OST   = 3'h1,
        CK_LOCK  = 3'h2,
        CK_READY = 3'h4
    } clk_state_t;
endpackage

// [inc/delay_timer_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface delay_timer_if;
    logic                               load;
    logic [reset_seq_pkg::TIMER_W-1:0]  len;
    logic                               done;
    logic                               busy;
    modport timer (input load, input len, output done, output busy);
    modport ctrl  (output load, output len, input done, input busy);
endinterface
`default_nettype wire

// [rtl/delay_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    delay_timer_if.timer tif
);
    import reset_seq_pkg::*;
    logic [TIMER_W-1:0] count_r;
    logic [TIMER_W-1:0] count_nxt;
    logic               done_r;
    logic               done_nxt;

    // a load of zero cancels a running count without a done pulse
    always_comb begin
        count_nxt = count_r;
        done_nxt  = 1'b0;
        if (tif.load) begin
            count_nxt = tif.len;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
            done_nxt  = (count_r == TIMER_W'(1));
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count_r <= '0;
            done_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign tif.done = done_r;
    assign tif.busy = (count_r != '0);
endmodule
`default_nettype wire

// [sim/osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input  wire logic clk_i,
    input  wire logic en_i,
    output logic      osc_clk_o
);
    logic [2:0] cnt_r;
    // stands low while disabled, as a crystal that has not started
    always_ff @(posedge clk_i) begin
        cnt_r     <= (!en_i || cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
        osc_clk_o <= en_i && ((cnt_r == 3'h4) ? !osc_clk_o : osc_clk_o);
    end
endmodule
`default_nettype wire

// [sim/test_reset_cause_and_delay_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_and_delay_sequencer;
    import reset_seq_pkg::*;
    localparam int TR = 8;
    logic clk_i = 0, rst_b_i = 0, rd = 0, wr = 0, bo = 0, pin_b = 1, pidle = 0, psave = 0;
    logic sw = 1, reg_en = 1, fuse = 0, osc_en = 0, wt, sr, cr, run, fsm, wde, osc;
    logic [3:0]  addr = 0;
    logic [4:0]  ev = 0;
    logic [2:0]  sel;
    logic [15:0] cfg = 0;
    logic [31:0] wd = 0, rdat, q, d;
    int n_errors = 0, n_compared = 0, cyc = 0, n, t0, sm;
    int evbit[5] = '{WATCHDOG_TIMEOUT_FLAG_BIT, SWR_BIT, ILLEGAL_BIT, TRAP_BIT, CM_BIT};
`define CHK(s, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", s, e, g); end end

    osc_model i_osc_model (.clk_i(clk_i), .en_i(osc_en), .osc_clk_o(osc));
    reset_cause_and_delay_sequencer #(.POWER_UP_TIMER_CYC(50), .LOCK_CYC(40), .FAIL_SAFE_MONITOR_CYC(20),
        .TRST_CYC(TR)) i_reset_cause_and_delay_sequencer (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wt), .brownout_i(bo), .master_clear_pin_b_i(pin_b),
        .osc_clk_i(osc), .watchdog_expire_i(ev[0]), .reset_instr_i(ev[1]),
        .illegal_op_i(ev[2]), .trap_conflict_i(ev[3]), .config_mismatch_i(ev[4]),
        .power_save_instruction_i(psave), .power_save_idle_i(pidle),
        .config_word_two_i(cfg), .clock_switch_en_i(sw), .regulator_enable_i(reg_en),
        .watchdog_fuse_enable_i(fuse), .system_reset_o(sr), .clock_release_o(cr),
        .cpu_run_o(run), .fail_safe_monitor_o(fsm), .osc_select_o(sel),
        .watchdog_enable_o(wde));

    initial forever #5 clk_i = !clk_i;

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr <= a; wd <= v; wr <= w; rd <= !w;
        do @(posedge clk_i); while (wt !== 1'b0);
        q = rdat;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic chk_rd(input logic [3:0] a, input int e);
        bus(1'b0, a, 32'h0);
        `CHK("readdata", e, q)
    endtask
    // measures the system reset pulse; cyc stamp kept for clock checks
    task automatic rst_len(input int lo, input int hi, input bit w);
        n = 0;
        while (sr !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        n = 0; t0 = cyc;
        while (sr === 1'b1) begin @(posedge clk_i); n++; end
        `CHK("rst_len", 1'b1, n >= lo && n <= hi)
        if (w) while (run !== 1'b1) @(posedge clk_i);
    endtask
    task automatic pin_rst(input logic [2:0] e);
        @(posedge clk_i); pin_b <= 1'b0;
        repeat (5) @(posedge clk_i); pin_b <= 1'b1;
        rst_len(TR, TR + 12, 1);
        `CHK("osc_sel", e, sel)
        sm |= 32'h80; chk_rd(STATUS_OFS, sm);
    endtask
    task end_of_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // no test should come near this; the long crystal count is about 10.3k cycles
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin n_errors++; end_of_test(); end
    end

    initial begin
        void'($urandom(93390));
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rst_len(2008, 2014, 1);
        @(posedge clk_i);
        sm = 3; chk_rd(STATUS_OFS, sm);
        `CHK("osc_sel", 3'h0, sel)
        `CHK("monitor", 1'b1, fsm)
        `CHK("wdt_en", 1'b0, wde)
        fuse <= 1'b1; repeat (3) @(posedge clk_i);
        `CHK("wdt_en", 1'b1, wde)
        $display("power-on test done");
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_i); ev <= 5'(1 << i);
            @(posedge clk_i); ev <= 5'h0;
            rst_len(TR, TR + 3, 1);
            sm |= 1 << evbit[i]; chk_rd(STATUS_OFS, sm);
        end
        @(posedge clk_i); pidle <= 1'b1; psave <= 1'b1;
        @(posedge clk_i); psave <= 1'b0;
        sm = (sm | 4) & ~32'h10; chk_rd(STATUS_OFS, sm);
        $display("event test done");
        repeat (4) begin
            d = $urandom; bus(1'b1, STATUS_OFS, d);
            sm = int'(d[15:0] & STATUS_MASK);
            `CHK("no_reset", 1'b0, sr)
            chk_rd(STATUS_OFS, sm);
        end
        chk_rd(4'h8, 0);
        bus(1'b1, OSC_CTL_OFS, 32'h4000);
        pin_rst(3'h4);
        sw <= 1'b0; cfg <= 16'h0100;
        pin_rst(3'h1);
        $display("software and pin test done");
        sw <= 1'b1; cfg <= 16'h0301; osc_en <= 1'b1;
        @(posedge clk_i); bo <= 1'b1;
        repeat (5) @(posedge clk_i); bo <= 1'b0;
        rst_len(1008, 1012, 0);
        n = 0;
        while (fsm !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
        `CHK("monitor_dly", 1'b1, n >= 20 && n <= 23)
        while (cr !== 1'b1) @(posedge clk_i);
        `CHK("clk_dly", 1'b1, cyc - t0 >= 10270 && cyc - t0 <= 10320)
        `CHK("osc_sel", 3'h3, sel)
        $display("brownout test done");
        end_of_test();
    end
endmodule
`default_nettype wire
